/* File: sbpr_pin_model.sv */
/*
 * Model of the circuitry outside the six port pins.
 * Assumes the bench supplies the level of every pin that the port leaves undriven.
 */
`timescale 1ns/1ps

module sbpr_pin_model
	import sbpr_pkg::*;
(
	input wire sbpr_pad_t pad,
	input wire logic [5:0] extLevel,
	output logic [5:0] padIn
);
	assign padIn = (pad.enable & pad.level) | (~pad.enable & extLevel);
endmodule

/* File: sbpr_pkg.sv */
/*
 * Package for the six-bit port register block: APB offsets, bit masks,
 * reset values and the pad bundle type.
 * Assumes an APB4 master with 32-bit data and byte-aligned word offsets.
 */
package sbpr_pkg;

	// ********************************
	// Register offsets
	// ********************************
	localparam logic [7:0] SBPR_PIN_VALUE_OFF = 8'h00;
	localparam logic [7:0] SBPR_DIRECTION_OFF = 8'h04;
	localparam logic [7:0] SBPR_OUT_LATCH_OFF = 8'h08;
	localparam logic [7:0] SBPR_ANALOG_SEL_OFF = 8'h0C;
	localparam logic [7:0] SBPR_CONFIG_OFF = 8'h10;

	// ********************************
	// Field layout
	// ********************************
	localparam int SBPR_PINS = 6;
	localparam int SBPR_INPUT_ONLY_BIT = 3;
	localparam int SBPR_EXT_RESET_EN_BIT = 0;
	localparam logic [5:0] SBPR_IMPL_MASK = 6'h37;
	localparam logic [5:0] SBPR_INPUT_ONLY_MASK = 6'h08;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [5:0] SBPR_DIRECTION_RST = 6'h3F;
	localparam logic [5:0] SBPR_ANALOG_SEL_RST = 6'h37;
	localparam logic SBPR_EXT_RESET_EN_RST = 1'b0;

	// Pad drive bundle
	typedef struct packed {
		logic [5:0] level;
		logic [5:0] enable;
	} sbpr_pad_t;

endpackage

/* File: sbpr_port.sv */
/*
 * Six-bit bidirectional port: pin level, direction and output latch
 * registers behind an APB4 slave, plus analog select and configuration.
 * Assumes pad inputs already synchronous to clock and a zero-wait master.
 */
// Local design decisions: the placing of the registers and the APB register port.
// Summary of operation
// - Pin-value read returns live pin levels in bits five to zero.
// - Writing pin-value stores into the output latch, never drives pins.
// - Pin-value reads show pins, not latch contents.
// - Pin-value bit three reads one when external reset pin enabled.
// - Direction one tri-states the driver; zero drives the latch value.
// - Direction bit three is unimplemented and reads one.
// - Latch holds outputs for pins five, four, two, one, zero.
// - Bits seven and six, and latch bit three, read zero.
// - Direction sets on every reset; latch keeps its value.
// - Pin-value writes without byte strobe zero are read-modify-write into the output latch.
// - Analog-selected pins read zero through pin-value.
`timescale 1ns/1ps

module sbpr_port
	import sbpr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] padIn,
	output sbpr_pad_t pad
);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [5:0] keepImpl(input logic [5:0] newV,
		input logic [5:0] oldV);
		keepImpl = (newV & SBPR_IMPL_MASK) | (oldV & ~SBPR_IMPL_MASK);
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	// ********************************
	// State
	// ********************************
	logic [5:0] dirQ;
	logic [5:0] latchQ;
	logic [5:0] anselQ;
	logic extResetEnQ;
	logic [31:0] prdataQ;
	logic [5:0] pinRead;
	logic [5:0] dirRead;
	logic [5:0] latchRead;
	logic [31:0] readMux;
	logic mapped;
	logic setup;
	logic wrAcc;
	logic lane0;
	logic [5:0] padEn;

	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite;
	// Only the low byte holds implemented bits
	assign lane0 = pstrb[0];
	assign mapped = hit(paddr, SBPR_PIN_VALUE_OFF) || hit(paddr, SBPR_DIRECTION_OFF)
		|| hit(paddr, SBPR_OUT_LATCH_OFF) || hit(paddr, SBPR_ANALOG_SEL_OFF)
		|| hit(paddr, SBPR_CONFIG_OFF);

	// ********************************
	// Read values
	// ********************************
	always_comb begin
		pinRead = padIn & SBPR_IMPL_MASK;
		pinRead[SBPR_INPUT_ONLY_BIT] = padIn[SBPR_INPUT_ONLY_BIT];
		pinRead = pinRead & ~anselQ;
		if (extResetEnQ) begin
			pinRead[SBPR_INPUT_ONLY_BIT] = 1'b1;
		end
	end

	assign dirRead = dirQ | SBPR_INPUT_ONLY_MASK;
	assign latchRead = latchQ & SBPR_IMPL_MASK;

	// Unmapped offsets fall through to zero so no stale value leaks out
	always_comb begin
		readMux = 32'h0000_0000;
		if (hit(paddr, SBPR_PIN_VALUE_OFF)) begin
			readMux[5:0] = pinRead;
		end else if (hit(paddr, SBPR_DIRECTION_OFF)) begin
			readMux[5:0] = dirRead;
		end else if (hit(paddr, SBPR_OUT_LATCH_OFF)) begin
			readMux[5:0] = latchRead;
		end else if (hit(paddr, SBPR_ANALOG_SEL_OFF)) begin
			readMux[5:0] = anselQ & SBPR_IMPL_MASK;
		end else if (hit(paddr, SBPR_CONFIG_OFF)) begin
			readMux[SBPR_EXT_RESET_EN_BIT] = extResetEnQ;
		end
	end

	// ********************************
	// APB slave
	// ********************************
	// Read data is captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdataQ <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdataQ <= readMux;
		end
	end

	assign prdata = prdataQ;
	assign pready = 1'b1;
	// Error flagged only in the access phase, where the master samples it
	assign pslverr = psel && penable && !mapped;

	// ********************************
	// Direction register
	// ********************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dirQ <= SBPR_DIRECTION_RST;
		end else if (wrAcc && lane0 && hit(paddr, SBPR_DIRECTION_OFF)) begin
			dirQ <= keepImpl(pwdata[5:0], dirQ);
		end
	end

	// ********************************
	// Output latch
	// ********************************
	// latch not reset
	// No reset: the latch keeps its content through warm resets
	always_ff @(posedge clock) begin
		if (wrAcc && hit(paddr, SBPR_PIN_VALUE_OFF)) begin
			if (lane0) begin
				latchQ <= keepImpl(pwdata[5:0], latchQ);
			end else begin
				latchQ <= keepImpl(pinRead, latchQ);
			end
		end else if (wrAcc && lane0 && hit(paddr, SBPR_OUT_LATCH_OFF)) begin
			latchQ <= keepImpl(pwdata[5:0], latchQ);
		end
	end

	// ********************************
	// Analog select and configuration
	// ********************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			anselQ <= SBPR_ANALOG_SEL_RST;
		end else if (wrAcc && lane0 && hit(paddr, SBPR_ANALOG_SEL_OFF)) begin
			anselQ <= pwdata[5:0] & SBPR_IMPL_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			extResetEnQ <= SBPR_EXT_RESET_EN_RST;
		end else if (wrAcc && lane0 && hit(paddr, SBPR_CONFIG_OFF)) begin
			extResetEnQ <= pwdata[SBPR_EXT_RESET_EN_BIT];
		end
	end

	// ********************************
	// Pad drivers
	// ********************************
	// driver enabled when direction bit clear
	assign padEn = ~dirQ & SBPR_IMPL_MASK;
	assign pad = '{level: latchQ & padEn, enable: padEn};

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic [5:0] dirPrev;
	always_ff @(posedge clock) begin
		dirPrev <= dirQ;
	end

	pin_read_a: assert property (
		setup && !pwrite && hit(paddr, SBPR_PIN_VALUE_OFF) && !extResetEnQ
		|=> prdata[5:0] == ($past(padIn) & ~$past(anselQ)))
		else $error("pin value read does not match pins");

	latch_write_a: assert property (
		wrAcc && lane0 && hit(paddr, SBPR_PIN_VALUE_OFF)
		|=> latchQ[5:4] == $past(pwdata[5:4]) && latchQ[2:0] == $past(pwdata[2:0])
			&& dirQ == dirPrev)
		else $error("pin value write did not reach latch");

	reset_pin_a: assert property (
		setup && !pwrite && hit(paddr, SBPR_PIN_VALUE_OFF) && extResetEnQ
		|=> prdata[SBPR_INPUT_ONLY_BIT])
		else $error("input-only bit not one with reset pin enabled");

	pad_drive_a: assert property (
		pad.enable == ~dirRead && !pad.enable[SBPR_INPUT_ONLY_BIT])
		else $error("driver enable does not follow direction");

	dir_write_a: assert property (
		wrAcc && lane0 && hit(paddr, SBPR_DIRECTION_OFF)
		|=> dirQ == (($past(pwdata[5:0]) & SBPR_IMPL_MASK) | SBPR_INPUT_ONLY_MASK))
		else $error("direction write did not land as expected");

	strobe_off_a: assert property (
		wrAcc && !lane0 && hit(paddr, SBPR_DIRECTION_OFF)
		|=> $stable(dirQ))
		else $error("direction changed without its byte strobe");

	dir_bit3_a: assert property (
		setup && !pwrite && hit(paddr, SBPR_DIRECTION_OFF)
		|=> prdata[SBPR_INPUT_ONLY_BIT] && prdata[31:6] == 26'h0)
		else $error("direction bit three not one");

	latch_out_a: assert property (
		wrAcc && lane0 && hit(paddr, SBPR_OUT_LATCH_OFF) && !pwdata[0]
		##1 pad.enable[0] |-> !pad.level[0])
		else $error("driven pin does not show latch");

	level_follow_a: assert property (
		((pad.level ^ latchRead) & pad.enable) == 6'h00
		&& (pad.level & ~pad.enable) == 6'h00)
		else $error("pad level does not follow the latch");

	pin_no_drive_a: assert property (
		wrAcc && hit(paddr, SBPR_PIN_VALUE_OFF)
		|=> $stable(pad.enable))
		else $error("pin value write changed the drivers");

	upper_zero_a: assert property (
		setup && !pwrite |=> prdata[31:6] == 26'h0)
		else $error("unimplemented bits read nonzero");

	unmapped_zero_a: assert property (
		setup && !pwrite && !mapped
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero");

	read_hold_a: assert property (
		psel && penable
		|=> $stable(prdata))
		else $error("read data moved after the access phase");

	reset_dir_a: assert property (
		@(posedge clock) disable iff (1'b0) !rst_n |=> dirQ == SBPR_DIRECTION_RST)
		else $error("direction not set after reset");

	reset_ansel_a: assert property (
		@(posedge clock) disable iff (1'b0)
		!rst_n |=> anselQ == SBPR_ANALOG_SEL_RST && !extResetEnQ)
		else $error("analog select or config not reset");

	rmw_latch_a: assert property (
		wrAcc && !lane0 && hit(paddr, SBPR_PIN_VALUE_OFF)
		|=> latchQ[1:0] == ($past(padIn[1:0]) & ~$past(anselQ[1:0])))
		else $error("read-modify-write did not sample pins");

	analog_zero_a: assert property (
		setup && !pwrite && hit(paddr, SBPR_PIN_VALUE_OFF)
		|=> (prdata[5:0] & $past(anselQ) & SBPR_IMPL_MASK) == 6'h00)
		else $error("analog pin read nonzero");

	unimpl_wr_a: assert property (
		wrAcc && hit(paddr, SBPR_OUT_LATCH_OFF)
		|=> $stable(latchQ[SBPR_INPUT_ONLY_BIT]) && latchRead[SBPR_INPUT_ONLY_BIT] == 1'b0)
		else $error("unimplemented latch bit changed");

	wr_then_read_c: cover property (
		wrAcc && hit(paddr, SBPR_PIN_VALUE_OFF) ##2
		setup && !pwrite && hit(paddr, SBPR_PIN_VALUE_OFF));
	drive_out_c: cover property (pad.enable != 6'h00);
	unmapped_c: cover property (pslverr);
	reset_pin_c: cover property (extResetEnQ && setup && hit(paddr, SBPR_PIN_VALUE_OFF));
	rmw_c: cover property (wrAcc && !lane0 && hit(paddr, SBPR_PIN_VALUE_OFF));

endmodule

/* File: tb.sv */
/*
 * Self-checking bench for the six-bit port registers.
 * Assumes the zero-wait APB slave and pin model beside it.
 */
`timescale 1ns/1ps

module tb;
	import sbpr_pkg::*;
	logic clock = 1'b0;
	logic rstN = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] padIn;
	logic [5:0] extLevel = 6'h00;
	sbpr_pad_t pad;
	int errTotal = 0;
	int samplesChecked = 0;
	int cyc = 0;

	always #50 clock = ~clock;

	sbpr_port i_sbpr_port (.clock(clock), .rst_n(rstN), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .padIn(padIn), .pad(pad));
	sbpr_pin_model i_sbpr_pin_model (.pad(pad), .extLevel(extLevel), .padIn(padIn));

	task automatic printVerdict;
		$display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errTotal++;
			printVerdict();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; answer taken at the edge where pready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic er);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, s, r, e);
	endtask

	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0, 4'hF, r, e);
		chk(name, exp, r);
	endtask

	task automatic tResetVals;
		logic [31:0] r;
		logic e;
		rdChk("direction", SBPR_DIRECTION_OFF, 32'h3F);
		rdChk("analogSel", SBPR_ANALOG_SEL_OFF, {26'h0, SBPR_ANALOG_SEL_RST});
		rdChk("config", SBPR_CONFIG_OFF, 32'h0);
		xfer(1'b0, 8'h40, 32'h0, 4'hF, r, e);
		chk("unmappedErr", 32'h1, {31'h0, e});
		chk("unmappedData", 32'h0, r);
	endtask

	task automatic tOutputs;
		wr(SBPR_ANALOG_SEL_OFF, 32'h0, 4'hF);
		wr(SBPR_OUT_LATCH_OFF, 32'hFFFFFFFF, 4'hF);
		rdChk("latch", SBPR_OUT_LATCH_OFF, 32'h37);
		wr(SBPR_DIRECTION_OFF, 32'h0, 4'hF);
		rdChk("direction", SBPR_DIRECTION_OFF, 32'h08);
		#1;
		chk("padEnable", 32'h37, {26'h0, pad.enable});
		chk("padLevel", 32'h37, {26'h0, pad.level});
		rdChk("pins", SBPR_PIN_VALUE_OFF, 32'h37);
		wr(SBPR_PIN_VALUE_OFF, 32'h12, 4'hF);
		rdChk("latch", SBPR_OUT_LATCH_OFF, 32'h12);
		#1;
		chk("padLevel", 32'h12, {26'h0, pad.level});
	endtask

	task automatic tInputs;
		wr(SBPR_DIRECTION_OFF, 32'h3F, 4'hF);
		extLevel <= 6'h2D;
		rdChk("pins", SBPR_PIN_VALUE_OFF, 32'h2D);
		rdChk("latch", SBPR_OUT_LATCH_OFF, 32'h12);
		extLevel <= 6'h25;
		wr(SBPR_PIN_VALUE_OFF, 32'h0, 4'h0);
		rdChk("latch", SBPR_OUT_LATCH_OFF, 32'h25);
	endtask

	task automatic tSpecial;
		extLevel <= 6'h00;
		wr(SBPR_CONFIG_OFF, 32'h1, 4'hF);
		rdChk("pins", SBPR_PIN_VALUE_OFF, 32'h08);
		wr(SBPR_CONFIG_OFF, 32'h0, 4'hF);
		wr(SBPR_ANALOG_SEL_OFF, 32'h1, 4'hF);
		extLevel <= 6'h3F;
		wr(SBPR_PIN_VALUE_OFF, 32'h25, 4'hF);
		rdChk("pins", SBPR_PIN_VALUE_OFF, 32'h3E);
	endtask

	task automatic tReset2;
		wr(SBPR_DIRECTION_OFF, 32'h0, 4'hF);
		rstN <= 1'b0;
		repeat (2) @(posedge clock);
		rstN <= 1'b1;
		rdChk("direction", SBPR_DIRECTION_OFF, 32'h3F);
		rdChk("latch", SBPR_OUT_LATCH_OFF, 32'h25);
		chk("padEnable", 32'h0, {26'h0, pad.enable});
		wr(SBPR_DIRECTION_OFF, 32'h0, 4'h0);
		rdChk("direction", SBPR_DIRECTION_OFF, 32'h3F);
	endtask

	initial begin
		repeat (3) @(posedge clock);
		rstN <= 1'b1;
		tResetVals();
		tOutputs();
		tInputs();
		tSpecial();
		tReset2();
		printVerdict();
	end
endmodule
